// ==== scbu_params.svh ====
// constants for the skip and branch condition unit
//
// Functional notes
// - skip-reg-bit-set skips the next instruction when the register bit is 1.
// - skip-io-bit-clear skips the next instruction when the I/O bit reads 0.
// - skip-io-bit-set skips the next instruction when the I/O bit reads 1.
// - branch-flag-set loads pc+k+1 when status bit s is 1.
// - branch-flag-clear loads pc+k+1 when status bit s is 0.
// - branch-equal jumps to pc+k+1 only when the zero flag is 1.
// - branch-not-equal jumps to pc+k+1 only when the zero flag is 0.
// - branch-carry-set jumps to pc+k+1 when the carry flag is 1.
// - branch-carry-clear and same-or-higher jump to pc+k+1 when carry is 0.
// - skip-reg-bit-clear skips the next instruction when the register bit is 0.
`ifndef SCBU_PARAMS_SVH
`define SCBU_PARAMS_SVH

`define SCBU_PC_W 16
// opcode masks and match values
`define SCBU_SKIP_REG_MASK 16'hFE08
`define SCBU_SKIP_REG_CLR_VAL 16'hFC00
`define SCBU_SKIP_REG_SET_VAL 16'hFE00
`define SCBU_SKIP_IO_MASK 16'hFF00
`define SCBU_SKIP_IO_CLR_VAL 16'h9900
`define SCBU_SKIP_IO_SET_VAL 16'h9B00
`define SCBU_BRANCH_MASK 16'hFC00
`define SCBU_BRANCH_SET_VAL 16'hF000
`define SCBU_BRANCH_CLR_VAL 16'hF400
// field positions
`define SCBU_BIT_HI 2
`define SCBU_BIT_LO 0
`define SCBU_REG_HI 8
`define SCBU_REG_LO 4
`define SCBU_IO_HI 7
`define SCBU_IO_LO 3
`define SCBU_K_HI 9
`define SCBU_K_LO 3
// status flag positions used by the alias branches
`define SCBU_FLAG_C 3'h0
`define SCBU_FLAG_Z 3'h1
// pc steps and extra busy cycles
`define SCBU_STEP_SEQ 16'h0001
`define SCBU_STEP_SKIP1 16'h0002
`define SCBU_STEP_SKIP2 16'h0003
`define SCBU_EXTRA_SKIP1 2'h1
`define SCBU_EXTRA_SKIP2 2'h2
`define SCBU_EXTRA_BRANCH 2'h1

`endif

// ==== scbu_pkg.sv ====
// types for the skip and branch condition unit
package scbu_pkg;
  typedef enum logic [2:0] {
    SCBU_OP_NONE,
    SCBU_OP_SKIP_REG_CLR,
    SCBU_OP_SKIP_REG_SET,
    SCBU_OP_SKIP_IO_CLR,
    SCBU_OP_SKIP_IO_SET,
    SCBU_OP_BRANCH_SET,
    SCBU_OP_BRANCH_CLR
  } scbu_op_t;

  typedef enum logic {
    SCBU_IDLE,
    SCBU_HOLD
  } scbu_state_t;
endpackage : scbu_pkg

// ==== scbu_cond.sv ====
// condition evaluator: picks one bit and compares it with the wanted level
`timescale 1ns/100ps
module scbu_cond (
  input wire scbu_pkg::scbu_op_t op, // decoded operation
  input wire logic [2:0] bit_sel, // bit or flag index from the opcode
  input wire logic [7:0] reg_rdata, // working register value
  input wire logic [7:0] io_rdata, // i/o register value
  input wire logic [7:0] status, // status register value
  output logic taken // condition holds, pc leaves sequence
);
  // single bit pick, shared by all three sources
  function automatic logic scbu_bit_of(input logic [7:0] value, input logic [2:0] sel);
    scbu_bit_of = value[sel];
  endfunction : scbu_bit_of

  // flags are only read here, there is no write path to the status register
  always_comb begin
    unique case (op)
      scbu_pkg::SCBU_OP_SKIP_REG_CLR: taken = !scbu_bit_of(reg_rdata, bit_sel);
      scbu_pkg::SCBU_OP_SKIP_REG_SET: taken = scbu_bit_of(reg_rdata, bit_sel);
      scbu_pkg::SCBU_OP_SKIP_IO_CLR: taken = !scbu_bit_of(io_rdata, bit_sel);
      scbu_pkg::SCBU_OP_SKIP_IO_SET: taken = scbu_bit_of(io_rdata, bit_sel);
      scbu_pkg::SCBU_OP_BRANCH_SET: taken = scbu_bit_of(status, bit_sel);
      scbu_pkg::SCBU_OP_BRANCH_CLR: taken = !scbu_bit_of(status, bit_sel);
      default: taken = 1'b0;
    endcase
  end
endmodule : scbu_cond

// ==== scbu_core.sv ====
// skip and relative branch decode, condition test and pc update
`timescale 1ns/100ps
`include "scbu_params.svh"
module scbu_core (
  input wire logic clk_sys, // core clock
  input wire logic rst, // async reset, active high
  input wire logic instr_valid, // fetch offers an instruction
  input wire logic [15:0] instr, // instruction word
  input wire logic [`SCBU_PC_W-1:0] pc, // word address of instr
  input wire logic next_two_word, // instruction after instr is two words long
  input wire logic [7:0] reg_rdata, // register file read data, same cycle
  input wire logic [7:0] io_rdata, // i/o space read data, same cycle
  input wire logic [7:0] status, // status register flags
  output logic instr_ready, // unit can take an instruction
  output logic [4:0] reg_raddr, // register file read address
  output logic [4:0] io_raddr, // i/o space read address
  output logic done, // pulse: result of last instruction valid
  output logic pc_load, // pulse: fetch must load pc_target
  output logic [`SCBU_PC_W-1:0] pc_target, // next pc of last instruction
  output logic flush // pulse: drop the instruction fetched in sequence
);
  // whole state in one record so reset and next state stay in step
  typedef struct packed {
    scbu_pkg::scbu_state_t state;
    logic [1:0] cnt;
    logic done;
    logic pc_load;
    logic flush;
    logic [`SCBU_PC_W-1:0] pc_target;
  } scbu_core_q_t;

  scbu_core_q_t q;
  scbu_core_q_t next_q;
  scbu_pkg::scbu_op_t op;
  logic taken;
  logic issue;
  logic [`SCBU_PC_W-1:0] k_off;

  // opcode decode; unknown words map to none and are never taken
  function automatic scbu_pkg::scbu_op_t scbu_decode(input logic [15:0] w);
    if ((w & `SCBU_SKIP_REG_MASK) == `SCBU_SKIP_REG_CLR_VAL) begin
      scbu_decode = scbu_pkg::SCBU_OP_SKIP_REG_CLR;
    end else if ((w & `SCBU_SKIP_REG_MASK) == `SCBU_SKIP_REG_SET_VAL) begin
      scbu_decode = scbu_pkg::SCBU_OP_SKIP_REG_SET;
    end else if ((w & `SCBU_SKIP_IO_MASK) == `SCBU_SKIP_IO_CLR_VAL) begin
      scbu_decode = scbu_pkg::SCBU_OP_SKIP_IO_CLR;
    end else if ((w & `SCBU_SKIP_IO_MASK) == `SCBU_SKIP_IO_SET_VAL) begin
      scbu_decode = scbu_pkg::SCBU_OP_SKIP_IO_SET;
    end else if ((w & `SCBU_BRANCH_MASK) == `SCBU_BRANCH_SET_VAL) begin
      scbu_decode = scbu_pkg::SCBU_OP_BRANCH_SET;
    end else if ((w & `SCBU_BRANCH_MASK) == `SCBU_BRANCH_CLR_VAL) begin
      scbu_decode = scbu_pkg::SCBU_OP_BRANCH_CLR;
    end else begin
      scbu_decode = scbu_pkg::SCBU_OP_NONE;
    end
  endfunction : scbu_decode

  // true for the four skip kinds
  function automatic logic scbu_is_skip(input scbu_pkg::scbu_op_t o);
    scbu_is_skip = (o == scbu_pkg::SCBU_OP_SKIP_REG_CLR) || (o == scbu_pkg::SCBU_OP_SKIP_REG_SET)
      || (o == scbu_pkg::SCBU_OP_SKIP_IO_CLR) || (o == scbu_pkg::SCBU_OP_SKIP_IO_SET);
  endfunction : scbu_is_skip

  // read addresses come straight from the word so data returns in the issue cycle
  assign op = scbu_decode(instr);
  assign reg_raddr = instr[`SCBU_REG_HI:`SCBU_REG_LO];
  assign io_raddr = instr[`SCBU_IO_HI:`SCBU_IO_LO];
  assign instr_ready = (q.state == scbu_pkg::SCBU_IDLE);
  assign issue = instr_valid && instr_ready && (op != scbu_pkg::SCBU_OP_NONE);
  // signed word displacement, sign bit copied upward
  assign k_off = {{(`SCBU_PC_W-7){instr[`SCBU_K_HI]}}, instr[`SCBU_K_HI:`SCBU_K_LO]};

  scbu_cond u_cond (
    .op(op),
    .bit_sel(instr[`SCBU_BIT_HI:`SCBU_BIT_LO]),
    .reg_rdata(reg_rdata),
    .io_rdata(io_rdata),
    .status(status),
    .taken(taken)
  );

  // next state: result is registered, extra cycles are spent in hold
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    next_q.pc_load = 1'b0;
    next_q.flush = 1'b0;
    unique case (q.state)
      scbu_pkg::SCBU_IDLE: begin
        if (issue) begin
          next_q.done = 1'b1;
          next_q.pc_target = pc + `SCBU_STEP_SEQ;
          if (taken && scbu_is_skip(op)) begin
            // the skipped word is never executed, so a flush covers it
            next_q.pc_load = 1'b1;
            next_q.flush = 1'b1;
            next_q.state = scbu_pkg::SCBU_HOLD;
            if (next_two_word) begin
              next_q.pc_target = pc + `SCBU_STEP_SKIP2;
              next_q.cnt = `SCBU_EXTRA_SKIP2;
            end else begin
              next_q.pc_target = pc + `SCBU_STEP_SKIP1;
              next_q.cnt = `SCBU_EXTRA_SKIP1;
            end
          end else if (taken) begin
            // equal, not-equal, carry aliases are these opcodes with s fixed
            next_q.pc_load = 1'b1;
            next_q.flush = 1'b1;
            next_q.state = scbu_pkg::SCBU_HOLD;
            next_q.pc_target = pc + k_off + `SCBU_STEP_SEQ;
            next_q.cnt = `SCBU_EXTRA_BRANCH;
          end
        end
      end
      // hold counts the busy cycles; the last one reopens the unit
      scbu_pkg::SCBU_HOLD: begin
        if (q.cnt == 2'h1) begin
          next_q.state = scbu_pkg::SCBU_IDLE;
        end
        next_q.cnt = q.cnt - 2'h1;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // every output below comes straight from a flip-flop
  assign done = q.done;
  assign pc_load = q.pc_load;
  assign pc_target = q.pc_target;
  assign flush = q.flush;

  // checks
  default clocking scbu_cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // helper picks for the checks
  logic bit_r;
  logic bit_i;
  logic is_br;
  logic [2:0] s_sel;
  assign bit_r = reg_rdata[instr[`SCBU_BIT_HI:`SCBU_BIT_LO]];
  assign bit_i = io_rdata[instr[`SCBU_BIT_HI:`SCBU_BIT_LO]];
  assign s_sel = instr[`SCBU_BIT_HI:`SCBU_BIT_LO];
  assign is_br = (op == scbu_pkg::SCBU_OP_BRANCH_SET) || (op == scbu_pkg::SCBU_OP_BRANCH_CLR);

  // shape of a taken skip seen from outside, one or two words long
  sequence skip_seq;
    ##1 (pc_load && flush && done && !instr_ready) ##1 (!done && !pc_load);
  endsequence

  chk_reg_set_skip: assert property (issue && op == scbu_pkg::SCBU_OP_SKIP_REG_SET && bit_r
    |-> skip_seq) else $error("register bit set did not skip");
  chk_io_clr_skip: assert property (issue && op == scbu_pkg::SCBU_OP_SKIP_IO_CLR && !bit_i
    && !next_two_word |=> pc_load && pc_target == $past(pc) + 16'h0002)
    else $error("i/o bit clear skip target wrong");
  chk_io_set_skip: assert property (issue && op == scbu_pkg::SCBU_OP_SKIP_IO_SET
    |=> pc_load == $past(bit_i)) else $error("i/o bit set skip mismatch");
  // flag branches, generic form
  chk_flag_set_br: assert property (issue && op == scbu_pkg::SCBU_OP_BRANCH_SET && status[s_sel]
    |=> pc_load && pc_target == $past(pc) + $past(k_off) + 16'h0001)
    else $error("flag set branch target wrong");
  chk_flag_clr_br: assert property (issue && op == scbu_pkg::SCBU_OP_BRANCH_CLR
    |=> pc_load == !$past(status[s_sel])) else $error("flag clear branch mismatch");
  // alias branches: s fixed at zero or carry
  chk_equal_br: assert property (issue && op == scbu_pkg::SCBU_OP_BRANCH_SET
    && s_sel == `SCBU_FLAG_Z |=> pc_load == $past(status[1])) else $error("equal branch wrong");
  chk_not_equal_br: assert property (issue && op == scbu_pkg::SCBU_OP_BRANCH_CLR
    && s_sel == `SCBU_FLAG_Z |=> pc_load != $past(status[1])) else $error("not equal branch wrong");
  chk_carry_set_br: assert property (issue && op == scbu_pkg::SCBU_OP_BRANCH_SET
    && s_sel == `SCBU_FLAG_C |=> pc_load == $past(status[0])) else $error("carry set branch wrong");
  chk_carry_clr_br: assert property (issue && op == scbu_pkg::SCBU_OP_BRANCH_CLR
    && s_sel == `SCBU_FLAG_C |=> pc_load != $past(status[0])) else $error("carry clear branch wrong");
  // skip length against the busy window
  chk_reg_clr_skip: assert property (issue && op == scbu_pkg::SCBU_OP_SKIP_REG_CLR && !bit_r
    && next_two_word |=> (pc_target == $past(pc) + 16'h0003) ##0 !instr_ready[*2]
    ##1 instr_ready) else $error("two word skip timing wrong");
  chk_skip_length: assert property (issue && scbu_is_skip(op) && next_two_word
    && op == scbu_pkg::SCBU_OP_SKIP_IO_SET && bit_i |-> ##1 (pc_load && !instr_ready)
    ##1 !instr_ready ##1 instr_ready) else $error("skip cycle count wrong");
  chk_branch_time: assert property (issue && is_br && !pc_load && q.state == scbu_pkg::SCBU_IDLE
    |=> ((done && (flush == pc_load))
    and (if (pc_load) (!instr_ready ##1 instr_ready) else instr_ready)))
    else $error("branch cycle count wrong");

  // handshake: refused cycles and ignored words give no answer
  chk_busy_refuse: assert property (!instr_ready |=> !done)
    else $error("answer while busy");
  chk_unknown_ignore: assert property (instr_valid && instr_ready
    && op == scbu_pkg::SCBU_OP_NONE |=> !done && instr_ready)
    else $error("unknown word answered");

  // untaken words step by one and the target holds until the next answer
  chk_untaken_step: assert property (issue && !taken
    |=> done && !pc_load && !flush && instr_ready && pc_target == $past(pc) + 16'h0001)
    else $error("untaken step wrong");
  chk_target_holds: assert property (!done |-> $stable(pc_target))
    else $error("target moved without an answer");

  // pulse pairing and hold counter sanity
  chk_flush_pairs: assert property (flush == pc_load)
    else $error("flush without load");
  chk_hold_count: assert property (q.state == scbu_pkg::SCBU_HOLD |-> q.cnt != 2'h0)
    else $error("hold with empty counter");

  // reset release is the trigger here, so this one is never disabled
  chk_reset_quiet: assert property (@(posedge clk_sys) disable iff (1'b0) $fell(rst)
    |-> instr_ready && !done && !pc_load && !flush && pc_target == 16'h0000)
    else $error("unit not idle after reset");

  // scenario covers
  cov_two_word_hold: cover property (issue ##1 !instr_ready ##1 !instr_ready ##1 instr_ready);
  cov_skip_one: cover property (issue && scbu_is_skip(op) && !next_two_word ##1 pc_load);
  cov_skip_two: cover property (issue && scbu_is_skip(op) && next_two_word ##1 pc_load);
  cov_branch_back: cover property (issue && is_br && instr[`SCBU_K_HI] ##1 pc_load);
  cov_untaken: cover property (issue ##1 done && !pc_load);
endmodule : scbu_core

// ==== scbu_tb.sv ====
// self-checking bench for the skip and branch condition unit
`timescale 1ns/100ps
`include "scbu_params.svh"
module tb;
  typedef struct packed {logic [15:0] tgt; logic ld;} scbu_exp_t;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [15:0] pc = 16'h0000;
  logic next_two_word = 1'b0;
  logic [7:0] reg_rdata = 8'h00;
  logic [7:0] io_rdata = 8'h00;
  logic [7:0] status = 8'h00;
  wire logic instr_ready, done, pc_load, flush;
  wire logic [4:0] reg_raddr, io_raddr;
  wire logic [15:0] pc_target;
  int err_total = 0;
  int check_count = 0;
  logic [31:0] seed = 32'h63BC260C;
  logic [31:0] r1, r2;
  scbu_exp_t exp_q[$];
  scbu_exp_t e;

  // 250 MHz core clock
  always #2 clk_sys = ~clk_sys;

  scbu_core u_dut (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .pc(pc), .next_two_word(next_two_word), .reg_rdata(reg_rdata), .io_rdata(io_rdata),
    .status(status), .instr_ready(instr_ready), .reg_raddr(reg_raddr), .io_raddr(io_raddr),
    .done(done), .pc_load(pc_load), .pc_target(pc_target), .flush(flush));

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift

  task automatic cmp1(input string name, input logic ev, input logic sv);
    check_count++;
    if (sv !== ev) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, ev, sv);
    end
  endtask : cmp1

  task automatic cmp16(input string name, input logic [15:0] ev, input logic [15:0] sv);
    check_count++;
    if (sv !== ev) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, ev, sv);
    end
  endtask : cmp16

  task automatic complete_run();
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // op 0 reg clr, 1 reg set, 2 io clr, 3 io set, 4 flag set, 5 flag clr; called at edge + 1
  task automatic issue(input int op, input logic [6:0] f, input logic [2:0] sel,
                       input logic [15:0] p, input logic ntw, input logic [7:0] d);
    logic [15:0] w;
    logic tk;
    int busy;
    scbu_exp_t ex;
    case (op)
      0: w = 16'hFC00 | {7'h00, f[4:0], 1'b0, sel};
      1: w = 16'hFE00 | {7'h00, f[4:0], 1'b0, sel};
      2: w = 16'h9900 | {8'h00, f[4:0], sel};
      3: w = 16'h9B00 | {8'h00, f[4:0], sel};
      4: w = 16'hF000 | {6'h00, f, sel};
      default: w = 16'hF400 | {6'h00, f, sel};
    endcase
    tk = (op == 0 || op == 2 || op == 5) ? !d[sel] : d[sel];
    instr_valid = 1'b1;
    instr = w;
    pc = p;
    next_two_word = ntw;
    // unused sources carry the inverse so a wrong pick shows
    reg_rdata = (op < 2) ? d : ~d;
    io_rdata = (op == 2 || op == 3) ? d : ~d;
    status = (op > 3) ? d : ~d;
    if (!tk) ex.tgt = p + 16'h0001;
    else if (op > 3) ex.tgt = p + {{9{f[6]}}, f} + 16'h0001;
    else ex.tgt = p + (ntw ? 16'h0003 : 16'h0002);
    ex.ld = tk;
    exp_q.push_back(ex);
    busy = !tk ? 0 : ((op < 4 && ntw) ? 2 : 1);
    #1;
    if (op < 2) cmp16("reg_raddr", {11'h000, f[4:0]}, {11'h000, reg_raddr});
    else if (op < 4) cmp16("io_raddr", {11'h000, f[4:0]}, {11'h000, io_raddr});
    @(posedge clk_sys);
    #1;
    // untaken words leave valid up so the next issue is back to back
    if (busy > 0) instr_valid = 1'b0;
    for (int i = 0; i < busy; i++) begin
      cmp1("instr_ready", 1'b0, instr_ready);
      @(posedge clk_sys);
      #1;
    end
    cmp1("instr_ready", 1'b1, instr_ready);
  endtask : issue

  // monitor: every done pulse consumes the oldest expectation
  always @(posedge clk_sys) begin
    #1;
    if (done === 1'b1) begin
      if (exp_q.size() == 0) begin
        cmp1("done", 1'b0, done);
      end else begin
        e = exp_q.pop_front();
        cmp16("pc_target", e.tgt, pc_target);
        cmp1("pc_load", e.ld, pc_load);
        cmp1("flush", e.ld, flush);
      end
    end else begin
      cmp1("pc_load", 1'b0, pc_load);
    end
  end

  // watchdog: the whole run needs about 2.4 us
  initial begin
    #40000;
    err_total++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    // every flag index at both levels, both offset extremes, pc wrapping
    for (int s = 0; s < 8; s++) begin
      for (int v = 0; v < 2; v++) begin
        for (int op = 4; op < 6; op++) begin
          issue(op, v ? 7'h40 : 7'h3F, s[2:0], 16'hFFF0, 1'b0,
                v ? (8'h01 << s) : ~(8'h01 << s));
        end
      end
    end
    // all four skips, bit level both ways, skipped word one and two long
    for (int op = 0; op < 4; op++) begin
      for (int v = 0; v < 4; v++) begin
        issue(op, 7'h1F - op[6:0], 3'((op + v) % 8), 16'h1234, v[1],
              v[0] ? 8'hFF : 8'h00);
      end
    end
    // a word of no skip or branch kind is ignored
    instr_valid = 1'b1;
    instr = 16'h0000;
    @(posedge clk_sys);
    #1;
    cmp1("instr_ready", 1'b1, instr_ready);
    instr_valid = 1'b0;
    // random mix
    repeat (300) begin
      r1 = xorshift();
      r2 = xorshift();
      issue(int'(r1 % 32'd6), r2[6:0], r2[9:7], r1[31:16], r2[10], r2[23:16]);
    end
    instr_valid = 1'b0;
    // a second reset in mid-run returns the unit to idle with a cleared target
    rst = 1'b1;
    @(posedge clk_sys);
    #1;
    cmp16("pc_target", 16'h0000, pc_target);
    cmp1("instr_ready", 1'b1, instr_ready);
    rst = 1'b0;
    // first request right after release: taken carry branch forward by one
    issue(4, 7'h01, 3'h0, 16'h0010, 1'b0, 8'h01);
    instr_valid = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    cmp16("pending", 16'h0000, 16'(exp_q.size()));
    complete_run();
  end
endmodule : tb
